/* tws_pkg.sv */
// Purpose: Constants and types for the two-wire slave receiver.
// Assumes: APB, 32-bit data, 50 MHz pclk.
// Notes:   Shared by the design and the bench.
// Function
// - Answer the seven-bit own address.
// - Address bit zero enables general call.
// - Write direction enters receive, read enters transmit (here a read reports A8 and is then let go, no transmit).
// - Own write address sets flag and status.
// - Lost arbitration then addressed gives 68 or 78.
// - Cleared acknowledge enable gives NACK next byte.
// - Acknowledge enable zero ignores address, keeps monitoring.
// - Deep sleep address match wakes the part.
// - Hold clock low until flag cleared.
// - Writing one clears the flag.
// - Data byte need not survive a wake.
// - General call ACKed reports 70.
// - ACKed own data reports 80, byte held.
// - NACKed data reports 88, then unaddressed.
// - After 88 recognise own, general if enabled.
// - After 88 with start request, await free bus.
// - STOP or repeated START while addressed reports A0.
package tws_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_DATA    = 12'h008;
  localparam logic [11:0] ADDR_OWN     = 12'h00C;
  localparam logic [11:0] ADDR_SLEEP   = 12'h010;
  // Control bit positions.
  localparam int CTL_FLAG  = 7;
  localparam int CTL_ACK   = 6;
  localparam int CTL_START = 5;
  localparam int CTL_STOP  = 4;
  localparam int CTL_WCOL  = 3;
  localparam int CTL_EN    = 2;
  localparam int CTL_IE    = 0;
  localparam int OWN_GCE   = 0;
  // Status codes.
  localparam logic [7:0] ST_IDLE     = 8'hF8;
  localparam logic [7:0] ST_OWN_ACK  = 8'h60;
  localparam logic [7:0] ST_ARB_OWN  = 8'h68;
  localparam logic [7:0] ST_GC_ACK   = 8'h70;
  localparam logic [7:0] ST_ARB_GC   = 8'h78;
  localparam logic [7:0] ST_DATA_ACK = 8'h80;
  localparam logic [7:0] ST_DATA_NAK = 8'h88;
  localparam logic [7:0] ST_GDAT_ACK = 8'h90;
  localparam logic [7:0] ST_GDAT_NAK = 8'h98;
  localparam logic [7:0] ST_STOP     = 8'hA0;
  localparam logic [7:0] ST_ST_ADDR  = 8'hA8;
  localparam logic [7:0] RESET_BYTE  = 8'h00;
  localparam logic [6:0] GC_ADDR     = 7'h00;
  // Timing.
  localparam int PCLK_MHZ      = 50;
  localparam int WAKE_NS       = 200;
  localparam int WAKE_CYCLES   = (WAKE_NS * PCLK_MHZ + 999) / 1000;
  typedef struct packed {
    logic scl;
    logic sda;
  } tws_pins_t;
  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } tws_ev_t;
endpackage

/* tws_line_monitor.sv */
// Purpose: Synchronise the bus lines and detect clock edges, START and STOP.
// Assumes: Lines are asynchronous to pclk.
// Notes:   Two flops then a history flop; only the second and history stages are read.
`timescale 1ns/1ns
module tws_line_monitor
  import tws_pkg::*;
(
  // Clock and reset.
  input  wire logic      pclk,
  input  wire logic      presetn,
  // Raw lines.
  input  wire tws_pins_t pins_in,
  // Decoded.
  output tws_pins_t      pins_s,
  output tws_ev_t        ev
);
  tws_pins_t meta_ff;
  tws_pins_t sync_ff;
  tws_pins_t prev_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '1;
      sync_ff <= '1;
      prev_ff <= '1;
    end else begin
      meta_ff <= pins_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end
  assign pins_s   = sync_ff;
  assign ev.rise  = sync_ff.scl & ~prev_ff.scl;
  assign ev.fall  = ~sync_ff.scl & prev_ff.scl;
  assign ev.start = sync_ff.scl & prev_ff.scl & prev_ff.sda & ~sync_ff.sda;
  assign ev.stop  = sync_ff.scl & prev_ff.scl & ~prev_ff.sda & sync_ff.sda;
endmodule

/* tws_slave_rx.sv */
// Purpose: Slave receiver of the two-wire unit with an APB register file.
// Assumes: SCL and SDA are open-drain; APB master holds requests until pready.
// Notes:   Master modes are outside this block; lost arbitration is an input.
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ns
module tws_slave_rx
  import tws_pkg::*;
(
  // APB.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Bus lines.
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             scl_oe,
  output logic             sda_oe,
  output logic             scl_out,
  output logic             sda_out,
  // System.
  input  wire logic        arb_lost,
  output logic             wake_req,
  output logic             start_pending
);
  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_ADDR  = 3'b001,
    S_AACK  = 3'b010,
    S_DATA  = 3'b011,
    S_DACK  = 3'b100,
    S_HOLD  = 3'b101,
    S_SKIP  = 3'b110
  } tws_state_t;

  tws_state_t  state_ff;
  logic [7:0]  ctl_ff;
  logic [7:0]  own_ff;
  logic [7:0]  status_ff;
  logic [7:0]  data_ff;
  logic [7:0]  shift_ff;
  logic [3:0]  bit_ff;
  logic        gc_ff;
  logic        rd_ff;
  logic        nak_ff;
  logic        addressed_ff;
  logic        sleep_ff;
  logic        wakeup_ff;
  logic [7:0]  wake_cnt_ff;
  logic        arb_ff;
  tws_pins_t   pins_s;
  tws_ev_t     ev;

  tws_line_monitor u_mon (
    .pclk    (pclk),
    .presetn (presetn),
    .pins_in ('{scl: scl_in, sda: sda_in}),
    .pins_s  (pins_s),
    .ev      (ev)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic wr_acc;
  logic rd_acc;
  logic known;
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  always_comb begin
    if (paddr == ADDR_CONTROL) begin
      known = 1'b1;
    end else if (paddr == ADDR_STATUS || paddr == ADDR_DATA) begin
      known = 1'b1;
    end else if (paddr == ADDR_OWN || paddr == ADDR_SLEEP) begin
      known = 1'b1;
    end else begin
      known = 1'b0;
    end
  end
  logic ctl_wr;
  logic flag_clr;
  assign ctl_wr   = wr_acc & (paddr == ADDR_CONTROL);
  assign flag_clr = ctl_wr & pwdata[CTL_FLAG];

  // ----------------------------------------------------------------
  // Protocol helpers
  // ----------------------------------------------------------------
  function automatic logic addr_match(input logic [7:0] sh, input logic [7:0] own);
    addr_match = (sh[7:1] == own[7:1]);
  endfunction
  function automatic logic gc_match(input logic [7:0] sh, input logic [7:0] own);
    gc_match = (sh[7:1] == GC_ADDR) & own[OWN_GCE];
  endfunction

  logic flag_set;
  logic [7:0] nxt_status;
  logic enabled;
  logic ack_en;
  assign enabled = ctl_ff[CTL_EN];
  assign ack_en  = ctl_ff[CTL_ACK];

  // ----------------------------------------------------------------
  // Receive state machine
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff     <= S_IDLE;
      shift_ff     <= RESET_BYTE;
      bit_ff       <= 4'h0;
      gc_ff        <= 1'b0;
      rd_ff        <= 1'b0;
      nak_ff       <= 1'b0;
      addressed_ff <= 1'b0;
      arb_ff       <= 1'b0;
    end else if (!enabled) begin
      state_ff     <= S_IDLE;
      addressed_ff <= 1'b0;
    end else if (ev.start || ev.stop) begin
      state_ff     <= ev.start ? S_ADDR : S_IDLE;
      bit_ff       <= 4'h0;
      addressed_ff <= 1'b0;
      arb_ff       <= arb_lost;
    end else begin
      case (state_ff)
        S_ADDR: begin
          if (ev.rise) begin
            shift_ff <= {shift_ff[6:0], pins_s.sda};
            bit_ff   <= bit_ff + 4'h1;
          end else if (ev.fall && bit_ff == 4'h8) begin
            // Address recognition only with acknowledge enabled
            if (ack_en && (addr_match(shift_ff, own_ff)
                || (!shift_ff[0] && gc_match(shift_ff, own_ff)))) begin
              state_ff     <= S_AACK;
              gc_ff        <= ~addr_match(shift_ff, own_ff);
              rd_ff        <= shift_ff[0];
              addressed_ff <= 1'b1;
            end else begin
              state_ff <= S_SKIP;
            end
          end
        end
        S_AACK: begin
          if (ev.fall) begin
            state_ff <= S_HOLD;
            bit_ff   <= 4'h0;
          end
        end
        S_HOLD: begin
          if (flag_clr) begin
            // Transmitting is outside this block, so a read transfer is let go here.
            state_ff <= (nak_ff || rd_ff) ? S_SKIP : S_DATA;
            nak_ff   <= 1'b0;
            if (nak_ff || rd_ff) begin
              addressed_ff <= 1'b0;
            end
          end
        end
        S_DATA: begin
          if (ev.rise) begin
            shift_ff <= {shift_ff[6:0], pins_s.sda};
            bit_ff   <= bit_ff + 4'h1;
          end else if (ev.fall && bit_ff == 4'h8) begin
            state_ff <= S_DACK;
            nak_ff   <= ~ack_en;
          end
        end
        S_DACK: begin
          if (ev.fall) begin
            state_ff <= S_HOLD;
            bit_ff   <= 4'h0;
          end
        end
        S_SKIP: begin
          state_ff <= S_SKIP;
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

  // Flag set events and their status codes.
  always_comb begin
    flag_set   = 1'b0;
    nxt_status = status_ff;
    if (enabled && (ev.start || ev.stop) && addressed_ff && state_ff == S_DATA) begin
      flag_set   = 1'b1;
      nxt_status = ST_STOP;
    end else if (enabled && ev.fall && state_ff == S_AACK) begin
      flag_set = 1'b1;
      if (rd_ff) begin
        nxt_status = ST_ST_ADDR;
      end else if (gc_ff) begin
        nxt_status = arb_ff ? ST_ARB_GC : ST_GC_ACK;
      end else begin
        nxt_status = arb_ff ? ST_ARB_OWN : ST_OWN_ACK;
      end
    end else if (enabled && ev.fall && state_ff == S_DACK) begin
      flag_set = 1'b1;
      if (gc_ff) begin
        nxt_status = nak_ff ? ST_GDAT_NAK : ST_GDAT_ACK;
      end else begin
        nxt_status = nak_ff ? ST_DATA_NAK : ST_DATA_ACK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_ff <= RESET_BYTE;
    end else begin
      if (ctl_wr) begin
        ctl_ff[CTL_ACK]   <= pwdata[CTL_ACK];
        ctl_ff[CTL_START] <= pwdata[CTL_START];
        ctl_ff[CTL_STOP]  <= pwdata[CTL_STOP];
        ctl_ff[CTL_EN]    <= pwdata[CTL_EN];
        ctl_ff[CTL_IE]    <= pwdata[CTL_IE];
      end
      // Set wins over a clear in the same cycle.
      if (flag_set) begin
        ctl_ff[CTL_FLAG] <= 1'b1;
      end else if (flag_clr) begin
        ctl_ff[CTL_FLAG] <= 1'b0;
      end
      if (wr_acc && paddr == ADDR_DATA && !ctl_ff[CTL_FLAG]) begin
        ctl_ff[CTL_WCOL] <= 1'b1;
      end else if (ctl_wr) begin
        ctl_ff[CTL_WCOL] <= pwdata[CTL_WCOL] & ctl_ff[CTL_WCOL];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_ff    <= RESET_BYTE;
      status_ff <= ST_IDLE;
      data_ff   <= RESET_BYTE;
      sleep_ff  <= 1'b0;
    end else begin
      if (wr_acc && paddr == ADDR_OWN) begin
        own_ff <= pwdata[7:0];
      end
      if (wr_acc && paddr == ADDR_SLEEP) begin
        sleep_ff <= pwdata[0];
      end
      if (flag_set) begin
        status_ff <= nxt_status;
      end
      // Asleep the byte is not latched, so data may be stale after waking.
      if (enabled && ev.fall && state_ff == S_DACK && !sleep_ff) begin
        data_ff <= shift_ff;
      end
    end
  end

  // Start request after 88: pending until the bus is free.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_pending <= 1'b0;
    end else if (flag_clr && status_ff == ST_DATA_NAK && pwdata[CTL_START]) begin
      // The request bit lands in this same write, so it is taken from the bus.
      start_pending <= 1'b1;
    end else if (ev.stop || !ctl_ff[CTL_START]) begin
      start_pending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sleep wake and line drive
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wakeup_ff   <= 1'b0;
      wake_cnt_ff <= 8'h00;
      wake_req    <= 1'b0;
    end else begin
      if (sleep_ff && ack_en && flag_set && state_ff == S_AACK) begin
        wakeup_ff   <= 1'b1;
        wake_cnt_ff <= 8'(WAKE_CYCLES);
        wake_req    <= 1'b1;
      end else begin
        wake_req <= 1'b0;
        if (wake_cnt_ff != 8'h00) begin
          wake_cnt_ff <= wake_cnt_ff - 8'h01;
        end
        if (flag_clr && wake_cnt_ff == 8'h00) begin
          wakeup_ff <= 1'b0;
        end
      end
    end
  end

  logic nxt_sda_oe;
  logic nxt_scl_oe;
  always_comb begin
    nxt_sda_oe = 1'b0;
    if (state_ff == S_AACK) begin
      nxt_sda_oe = 1'b1;
    end else if (state_ff == S_DACK) begin
      nxt_sda_oe = ~nak_ff;
    end
    nxt_scl_oe = (state_ff == S_HOLD && !pins_s.scl) || wakeup_ff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_oe  <= 1'b0;
      scl_oe  <= 1'b0;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end else begin
      sda_oe  <= nxt_sda_oe;
      scl_oe  <= nxt_scl_oe;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~known;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        if (paddr == ADDR_CONTROL) begin
          prdata <= {24'h000000, ctl_ff};
        end else if (paddr == ADDR_STATUS) begin
          prdata <= {24'h000000, status_ff};
        end else if (paddr == ADDR_DATA) begin
          prdata <= {24'h000000, data_ff};
        end else if (paddr == ADDR_OWN) begin
          prdata <= {24'h000000, own_ff};
        end else if (paddr == ADDR_SLEEP) begin
          prdata <= {31'h00000000, sleep_ff};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_addr_ack;
    state_ff == S_AACK && ev.fall && enabled;
  endsequence
  property p_addr_flag;
    @(posedge pclk) disable iff (!presetn)
    s_addr_ack |=> ctl_ff[CTL_FLAG];
  endproperty
  a_addr_flag: assert property (p_addr_flag) else $error("flag not set on address");
  property p_own_code;
    @(posedge pclk) disable iff (!presetn)
    (s_addr_ack and (!gc_ff && !rd_ff && !arb_ff && !(ev.start || ev.stop)))
      |=> status_ff == ST_OWN_ACK;
  endproperty
  a_own_code: assert property (p_own_code) else $error("own address code wrong");
  property p_gc_code;
    @(posedge pclk) disable iff (!presetn)
    (s_addr_ack and (gc_ff && !arb_ff)) |=> status_ff == ST_GC_ACK;
  endproperty
  a_gc_code: assert property (p_gc_code) else $error("general call code wrong");
  property p_arb_code;
    @(posedge pclk) disable iff (!presetn)
    (s_addr_ack and (arb_ff && !rd_ff)) |=> status_ff inside {ST_ARB_OWN, ST_ARB_GC};
  endproperty
  a_arb_code: assert property (p_arb_code) else $error("arbitration code wrong");
  property p_nak_drive;
    @(posedge pclk) disable iff (!presetn)
    state_ff == S_DACK && nak_ff |=> !sda_oe;
  endproperty
  a_nak_drive: assert property (p_nak_drive) else $error("sda driven on nack");
  property p_no_ack_disabled;
    @(posedge pclk) disable iff (!presetn)
    state_ff == S_ADDR && !ack_en |=> state_ff != S_AACK;
  endproperty
  a_no_ack_disabled: assert property (p_no_ack_disabled) else $error("acked while disabled");
  property p_clear_flag;
    @(posedge pclk) disable iff (!presetn)
    flag_clr && !flag_set |=> !ctl_ff[CTL_FLAG];
  endproperty
  a_clear_flag: assert property (p_clear_flag) else $error("flag not cleared");
  property p_stretch;
    @(posedge pclk) disable iff (!presetn)
    wakeup_ff |=> scl_oe;
  endproperty
  a_stretch: assert property (p_stretch) else $error("scl released in wake");
endmodule

/* tws_bus_master_model.sv */
// Purpose: Behavioural two-wire bus master transmitter facing the slave receiver.
// Assumes: The bench resolves both open-drain lines with pull-ups; 163 ns bit period.
// Notes:   Outputs are high while the model pulls a line low.
`timescale 1ns/1ns
module tws_bus_master_model (
  // Resolved lines.
  input  wire logic scl_line,
  input  wire logic sda_line,
  // Pull-down requests.
  output logic      scl_low,
  output logic      sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // Releasing the clock must wait out stretching, so no bit is shortened.
  task automatic rise_scl();
    scl_low = 1'b0;
    wait (scl_line === 1'b1);
    #3;
  endtask

  task automatic start_cond();
    #3;
    sda_low = 1'b1;
    #80;
    scl_low = 1'b1;
    #40;
  endtask

  task automatic stop_cond();
    #3;
    sda_low = 1'b1;
    #40;
    rise_scl();
    #80;
    sda_low = 1'b0;
    #80;
  endtask

  // Sends one byte MSB first and returns the line level of the ninth clock.
  task automatic send_byte(input logic [7:0] b, output logic nack);
    #3;
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      #40;
      rise_scl();
      #80;
      scl_low = 1'b1;
      #40;
    end
    sda_low = 1'b0;
    #40;
    rise_scl();
    #40;
    nack = sda_line;
    #40;
    scl_low = 1'b1;
    #40;
  endtask
endmodule

/* test_two_wire_slave_receiver.sv */
// Purpose: Self-checking bench of the two-wire slave receiver.
// Assumes: Status low three bits are masked before decoding.
// Notes:   Random bytes and the own address come from a fixed-seed shift register.
`timescale 1ns/1ns
module test_two_wire_slave_receiver;
  import tws_pkg::*;
  localparam logic [31:0] FLAGW   = 32'h1 << CTL_FLAG;
  localparam logic [31:0] CTL_RUN = (32'h1 << CTL_EN) | (32'h1 << CTL_ACK);
  logic        pclk, presetn, psel, penable, pwrite, arb_lost;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv, lfsr;
  logic        pready, pslverr, ev, scl_oe, sda_oe, scl_out, sda_out;
  logic        wake_req, start_pending, m_scl_low, m_sda_low, wake_seen;
  logic [6:0]  oa;
  logic [7:0]  d;
  wire         scl_line = (scl_oe ? scl_out : 1'b1) & ~m_scl_low;
  wire         sda_line = (sda_oe ? sda_out : 1'b1) & ~m_sda_low;
  int          miscompares, cmp_count, cycles;

  tws_slave_rx u_tws_slave_rx (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl_line), .sda_in(sda_line),
    .scl_oe(scl_oe), .sda_oe(sda_oe), .scl_out(scl_out), .sda_out(sda_out),
    .arb_lost(arb_lost), .wake_req(wake_req), .start_pending(start_pending));
  tws_bus_master_model u_master (.scl_line(scl_line), .sda_line(sda_line),
    .scl_low(m_scl_low), .sda_low(m_sda_low));

  always #10 pclk = ~pclk;

  always @(posedge pclk) begin
    cycles++;
    if (wake_req === 1'b1) begin
      wake_seen <= 1'b1;
    end
    if (cycles == 30000) begin
      miscompares++;
      $display("BAD %0t run did not finish", $time);
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // The request stands until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Status is read once the flag is up, or after 100 control reads without it.
  task automatic expect_event(input logic [7:0] st);
    int n;
    n  = 0;
    rv = 32'h0;
    while (rv[CTL_FLAG] !== 1'b1 && n < 100) begin
      apb(1'b0, ADDR_CONTROL, 32'h0);
      n++;
    end
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rv & 32'hF8, {24'h0, st});
  endtask

  task automatic addr_phase(input logic [7:0] ab, input logic ack, input logic [7:0] st);
    logic nk;
    u_master.start_cond();
    u_master.send_byte(ab, nk);
    check(32'(nk), 32'(!ack));
    if (ack) begin
      expect_event(st);
      check(32'({scl_oe, scl_line}), 32'h2);
    end else begin
      repeat (20) @(posedge pclk);
      apb(1'b0, ADDR_CONTROL, 32'h0);
      check(32'(rv[CTL_FLAG]), 32'h0);
      u_master.stop_cond();
    end
  endtask

  task automatic data_phase(input logic [31:0] ctl, input logic [7:0] b, input logic ack,
                            input logic [7:0] st);
    logic nk;
    apb(1'b1, ADDR_CONTROL, FLAGW | ctl);
    u_master.send_byte(b, nk);
    check(32'(nk), 32'(!ack));
    expect_event(st);
    apb(1'b0, ADDR_DATA, 32'h0);
    check(rv, {24'h0, b});
  endtask

  task automatic finish_a0();
    apb(1'b1, ADDR_CONTROL, FLAGW | CTL_RUN);
    u_master.stop_cond();
    expect_event(ST_STOP);
    apb(1'b1, ADDR_CONTROL, FLAGW | CTL_RUN);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {pclk, presetn, psel, penable, pwrite, arb_lost, wake_seen} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    {miscompares, cmp_count, cycles} = {32'h0, 32'h0, 32'h0};
    lfsr = 32'h000123D6;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rv, {24'h0, ST_IDLE});
    apb(1'b0, ADDR_CONTROL, 32'h0);
    check(rv, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    check({31'h0, ev}, 32'h1);
    $display("register test done");
    lfsr = next_rand(lfsr);
    oa = {1'b1, lfsr[5:0]};
    apb(1'b1, ADDR_OWN, {24'h0, oa, 1'b0});
    apb(1'b1, ADDR_CONTROL, CTL_RUN);
    addr_phase({oa, 1'b0}, 1'b1, ST_OWN_ACK);
    lfsr = next_rand(lfsr);
    d = lfsr[7:0];
    data_phase(CTL_RUN, d, 1'b1, ST_DATA_ACK);
    data_phase(32'h1 << CTL_EN, ~d, 1'b0, ST_DATA_NAK);
    apb(1'b1, ADDR_CONTROL, FLAGW | CTL_RUN | (32'h1 << CTL_START));
    @(posedge pclk);
    check(32'(start_pending), 32'h1);
    u_master.stop_cond();
    repeat (6) @(posedge pclk);
    check(32'(start_pending), 32'h0);
    $display("own address test done");
    apb(1'b1, ADDR_CONTROL, 32'h1 << CTL_EN);
    addr_phase({oa, 1'b0}, 1'b0, ST_OWN_ACK);
    apb(1'b1, ADDR_CONTROL, CTL_RUN);
    addr_phase({oa, 1'b0}, 1'b1, ST_OWN_ACK);
    finish_a0();
    addr_phase(8'h00, 1'b0, ST_GC_ACK);
    apb(1'b1, ADDR_OWN, {24'h0, oa, 1'b1});
    addr_phase(8'h00, 1'b1, ST_GC_ACK);
    lfsr = next_rand(lfsr);
    data_phase(CTL_RUN, lfsr[7:0], 1'b1, ST_GDAT_ACK);
    finish_a0();
    $display("enable and general call test done");
    for (int g = 0; g < 2; g++) begin
      @(posedge pclk);
      arb_lost <= 1'b1;
      addr_phase(g == 1 ? 8'h00 : {oa, 1'b0}, 1'b1, g == 1 ? ST_ARB_GC : ST_ARB_OWN);
      @(posedge pclk);
      arb_lost <= 1'b0;
      finish_a0();
    end
    $display("lost arbitration test done");
    apb(1'b1, ADDR_SLEEP, 32'h1);
    addr_phase({oa, 1'b0}, 1'b1, ST_OWN_ACK);
    check(32'(wake_seen), 32'h1);
    repeat (2 * WAKE_CYCLES) @(posedge pclk);
    check(32'({scl_oe, scl_line}), 32'h2);
    apb(1'b1, ADDR_SLEEP, 32'h0);
    finish_a0();
    $display("sleep wake test done");
    addr_phase({oa, 1'b1}, 1'b1, ST_ST_ADDR);
    $display("read direction test done");
    report_and_stop();
  end
endmodule
